// [core/sfec_exec_control.v]
// Execution sequencing for the register logical, shift, flag set/reset and flag test groups.
//
// What this block does
// - Logical group combines task or comm register part into R.
// - ROM logical group skips buffer wait; ROM advance.
// - Shift group shifts task register R by the T/N count.
// - Groups start at class 7 step 2; shifter gets R, opcode, count.
// - Unfinished shift steps by 1, 4, 8 or 16 and reduces count.
// - Partial shift writes word and count back, stays at 7/2.
// - Last shift with buffer writes no count, advances from buffer.
// - Dependency on last shift moves to 3/2.
// - Memory second step advances pipe from buffer word.
// - ROM shifts need no buffer; ROM advance.
// - ROM second step advances pipe the ROM way.
// - Flag set/reset alters processor's bit in T/N comm byte.
// - Bit altered in all four bytes; only addressed byte written.
// - Flag set/reset with buffer: dependency to 3/2, else advance.
// - ROM flag set/reset needs no buffer; ROM advance.
// - Flag test checks processor bit; success skips next instruction.
// - Test sees four bytes; skip uses polarity and aligner byte.
// - Failed test advances pipe from buffer word.
// - Passed test refetches from buffer address, increments PC, 3/2.
// - ROM flag test: skip applies PC to ROM, else ROM advance.
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "sfec_regs.vh"

module sfec_exec_control (
    input  wire        hclk,                      // Bus and core clock.
    input  wire        hresetn,                   // Asynchronous reset, active low.
    input  wire        hsel,                      // Slave select.
    input  wire [31:0] haddr,                     // Byte address.
    input  wire        hwrite,                    // High for a write.
    input  wire [1:0]  htrans,                    // Transfer type.
    input  wire [2:0]  hsize,                     // Transfer size, word only.
    input  wire [31:0] hwdata,                    // Write data.
    input  wire        hready,                    // Bus ready.
    output wire        hreadyout,                 // Slave ready, never stalls.
    output wire        hresp,                     // Always OKAY.
    output reg  [31:0] hrdata,                    // Read data.
    input  wire        buffer_avail,              // Buffer synchroniser has a word.
    input  wire        dependency,                // Next instruction needs this result first.
    input  wire [31:0] memory_buffer_data_word,   // Word held in the memory buffer.
    input  wire [15:0] memory_buffer_addr,        // Address of that word.
    input  wire [2:0]  active_processor_number,   // Executing virtual processor.
    input  wire [3:0]  aligner_byte_reference,    // One-hot byte under test.
    output reg         pipe_advance,              // Pulse: pipe moves one level.
    output reg         pipe_from_buffer,          // Pulse: next word taken from buffer.
    output reg         pipe_rom_method,           // Pulse: ROM-source advance used.
    output reg  [31:0] next_instruction,          // Word loaded on a buffer advance.
    output reg         read_request,              // Pulse: instruction read issued.
    output reg  [15:0] read_address,              // Address of that read.
    output reg         read_from_rom,             // Level with read_request: ROM read.
    output reg  [2:0]  state_class,               // Current state class.
    output reg  [1:0]  state_step,                // Current step.
    output reg         skip_taken                 // Last flag test skipped.
);

    // ****************************************************************
    // State codes.
    // ****************************************************************
    localparam ST_IDLE = 2'd0;
    localparam ST_C7S2 = 2'd1;
    localparam ST_C3S2 = 2'd2;

    reg  [1:0]  state;
    reg  [1:0]  grp;
    reg         rom_src;
    reg  [2:0]  op;
    reg  [1:0]  r_idx;
    reg  [5:0]  effective_address;
    reg  [1:0]  size;
    reg  [1:0]  lane;
    reg  [15:0] program_counter;
    reg  [31:0] task_general_register [0:3];
    reg  [31:0] communications_register [0:3];

    reg         ap_valid;
    reg         ap_write;
    reg  [7:0]  ap_addr;

    reg  [1:0]  next_state;
    reg         do_task;
    reg  [31:0] task_data;
    reg         do_ea;
    reg         do_cfile;
    reg  [31:0] cfile_data;
    reg         do_adv;
    reg         do_skip;

    wire [31:0] shift_result;
    wire [5:0]  updated_shift_count;
    wire        shift_update_flag;
    wire        go;
    wire [31:0] target;
    wire [31:0] main_data_bus;
    wire [31:0] operand;
    wire [31:0] logic_res;
    wire [31:0] flag_bits;
    wire [31:0] flag_res;
    wire [31:0] byte_keep;
    wire [3:0]  tested;
    wire        test_pass;
    wire        busy;
    integer     i;

    // ****************************************************************
    // Helper functions.
    // ****************************************************************
    // Byte lane mask for a two-bit lane number.
    function [31:0] lane_mask;
        input [1:0] ln;
        begin
            lane_mask = 32'h0000_00FF << {ln, 3'b000};
        end
    endfunction

    // The four logical operations: AND, OR, XOR, equivalence.
    function [31:0] logic_op;
        input [31:0] a;
        input [31:0] b;
        input [1:0]  o;
        begin
            case (o)
                2'd0: logic_op = a & b;
                2'd1: logic_op = a | b;
                2'd2: logic_op = a ^ b;
                default: logic_op = ~(a ^ b);
            endcase
        end
    endfunction

    // ****************************************************************
    // Datapath.
    // ****************************************************************
    // Memory groups need the buffer; ROM groups never wait.
    assign go = rom_src | buffer_avail;

    // R register, and the T/N register on the data bus; flag groups always use comm registers.
    assign target        = task_general_register[r_idx];
    assign main_data_bus = (effective_address[2] | grp[1]) ? communications_register[effective_address[1:0]]
                                                : task_general_register[effective_address[1:0]];

    // Source word, half or byte, zero extended.
    assign operand = (size == 2'd0) ? main_data_bus :
                     (size == 2'd1) ? ((main_data_bus >> {lane[1], 4'b0000}) & 32'h0000_FFFF) :
                                      ((main_data_bus & lane_mask(lane)) >> {lane, 3'b000});
    assign logic_res = logic_op(target, operand, op[1:0]);

    // The processor's flag bit in each of the four bytes.
    assign flag_bits = {4{8'h01 << active_processor_number}};
    assign flag_res  = op[0] ? (main_data_bus | flag_bits) : (main_data_bus & ~flag_bits);
    assign byte_keep = lane_mask(lane);

    // All four bytes are tested; the aligner picks the byte that counts.
    assign tested    = {main_data_bus[{2'd3, active_processor_number}],
                        main_data_bus[{2'd2, active_processor_number}],
                        main_data_bus[{2'd1, active_processor_number}],
                        main_data_bus[{2'd0, active_processor_number}]};
    assign test_pass = |(~(tested ^ {4{op[0]}}) & aligner_byte_reference);

    // Shifter works on R with the count in the effective address.
    sfec_shift_step u_shift (
        .word      (target),
        .kind      (op[1:0]),
        .left      (op[2]),
        .count     (effective_address),
        .result    (shift_result),
        .new_count (updated_shift_count),
        .more      (shift_update_flag)
    );

    // ****************************************************************
    // Sequencing decisions.
    // ****************************************************************
    // One pass decides every write and the next state.
    always @* begin
        next_state = state;
        do_task    = 1'b0;
        task_data  = logic_res;
        do_ea      = 1'b0;
        do_cfile   = 1'b0;
        cfile_data = (main_data_bus & ~byte_keep) | (flag_res & byte_keep);
        do_adv     = 1'b0;
        do_skip    = 1'b0;
        case (state)
            ST_C7S2: begin
                case (grp)
                    `SFEC_GRP_LOGIC: begin
                        if (go) begin
                            do_task    = 1'b1;
                            next_state = dependency ? ST_C3S2 : ST_IDLE;
                            do_adv     = ~dependency;
                        end
                    end
                    `SFEC_GRP_SHIFT: begin
                        task_data = shift_result;
                        if (shift_update_flag) begin
                            // Partial steps need no buffer; state stays at 7/2.
                            do_task = 1'b1;
                            do_ea   = 1'b1;
                        end else if (go) begin
                            do_task    = 1'b1;
                            next_state = dependency ? ST_C3S2 : ST_IDLE;
                            do_adv     = ~dependency;
                        end
                    end
                    `SFEC_GRP_FSET: begin
                        if (go) begin
                            do_cfile   = 1'b1;
                            next_state = dependency ? ST_C3S2 : ST_IDLE;
                            do_adv     = ~dependency;
                        end
                    end
                    default: begin
                        if (go) begin
                            do_skip    = test_pass;
                            do_adv     = ~test_pass;
                            next_state = test_pass ? ST_C3S2 : ST_IDLE;
                        end
                    end
                endcase
            end
            ST_C3S2: begin
                if (go) begin
                    do_adv     = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    assign busy = (state != ST_IDLE);

    // ****************************************************************
    // Bus slave.
    // ****************************************************************
    // No wait states, so ready and response are constant.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Address phase capture; only NONSEQ and SEQ transfers count.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr  <= 8'h00;
        end else if (hready) begin
            ap_valid <= hsel & htrans[1];
            ap_write <= hwrite;
            ap_addr  <= haddr[7:0];
        end
    end

    // Read data is fetched in the address phase so it stands in the data phase.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `SFEC_RST_WORD;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            if (haddr[7:0] == `SFEC_CTRL_OFS) begin
                hrdata <= {12'h000, lane, size, effective_address, r_idx, 1'b0, op, rom_src, grp, 1'b0};
            end else if (haddr[7:0] == `SFEC_STAT_OFS) begin
                hrdata <= {18'h00000, effective_address, 1'b0, skip_taken, state_step, state_class, busy};
            end else if (haddr[7:0] == `SFEC_PC_OFS) begin
                hrdata <= {16'h0000, program_counter};
            end else if ((haddr[7:0] & `SFEC_BANK_MASK) == `SFEC_TASK_BASE && haddr[1:0] == 2'b00) begin
                hrdata <= task_general_register[haddr[3:2]];
            end else if ((haddr[7:0] & `SFEC_BANK_MASK) == `SFEC_CFILE_BASE && haddr[1:0] == 2'b00) begin
                hrdata <= communications_register[haddr[3:2]];
            end else begin
                hrdata <= `SFEC_RST_WORD;
            end
        end
    end

    // ****************************************************************
    // Control state, registers and pipe strobes.
    // ****************************************************************
    // Software writes are ignored while busy, so the engine owns the files.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state             <= ST_IDLE;
            grp               <= `SFEC_GRP_LOGIC;
            rom_src           <= 1'b0;
            op                <= 3'd0;
            r_idx             <= 2'd0;
            effective_address <= 6'd0;
            size              <= 2'd0;
            lane              <= 2'd0;
            program_counter   <= `SFEC_RST_PC;
            pipe_advance      <= 1'b0;
            pipe_from_buffer  <= 1'b0;
            pipe_rom_method   <= 1'b0;
            next_instruction  <= `SFEC_RST_WORD;
            read_request      <= 1'b0;
            read_address      <= `SFEC_RST_PC;
            read_from_rom     <= 1'b0;
            skip_taken        <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                task_general_register[i]   <= `SFEC_RST_WORD;
                communications_register[i] <= `SFEC_RST_WORD;
            end
        end else begin
            pipe_advance     <= 1'b0;
            pipe_from_buffer <= 1'b0;
            pipe_rom_method  <= 1'b0;
            read_request     <= 1'b0;
            state            <= next_state;
            if (busy) begin
                if (do_task) begin
                    task_general_register[r_idx] <= task_data;
                end
                if (do_ea) begin
                    effective_address <= updated_shift_count;
                end
                if (do_cfile) begin
                    communications_register[effective_address[1:0]] <= cfile_data;
                end
                if (do_adv) begin
                    pipe_advance     <= 1'b1;
                    pipe_rom_method  <= rom_src;
                    pipe_from_buffer <= ~rom_src;
                    if (!rom_src) begin
                        next_instruction <= memory_buffer_data_word;
                    end
                end
                if (do_skip) begin
                    // Buffered word dropped: refetch, or PC to ROM.
                    skip_taken    <= 1'b1;
                    read_request  <= 1'b1;
                    read_from_rom <= rom_src;
                    if (rom_src) begin
                        read_address    <= program_counter;
                        program_counter <= program_counter + 16'h0001;
                    end else begin
                        read_address    <= memory_buffer_addr;
                        program_counter <= memory_buffer_addr + 16'h0001;
                    end
                end
            end else if (ap_valid && ap_write) begin
                if (ap_addr == `SFEC_CTRL_OFS) begin
                    grp               <= hwdata[`SFEC_CTRL_GRP_HI:`SFEC_CTRL_GRP_LO];
                    rom_src           <= hwdata[`SFEC_CTRL_ROM];
                    op                <= hwdata[`SFEC_CTRL_OP_HI:`SFEC_CTRL_OP_LO];
                    r_idx             <= hwdata[`SFEC_CTRL_R_HI:`SFEC_CTRL_R_LO];
                    effective_address <= hwdata[`SFEC_CTRL_TN_HI:`SFEC_CTRL_TN_LO];
                    size              <= hwdata[`SFEC_CTRL_SZ_HI:`SFEC_CTRL_SZ_LO];
                    lane              <= hwdata[`SFEC_CTRL_LN_HI:`SFEC_CTRL_LN_LO];
                    if (hwdata[`SFEC_CTRL_START]) begin
                        state      <= ST_C7S2;
                        skip_taken <= 1'b0;
                    end
                end else if (ap_addr == `SFEC_PC_OFS) begin
                    program_counter <= hwdata[15:0];
                end else if ((ap_addr & `SFEC_BANK_MASK) == `SFEC_TASK_BASE && ap_addr[1:0] == 2'b00) begin
                    task_general_register[ap_addr[3:2]] <= hwdata;
                end else if ((ap_addr & `SFEC_BANK_MASK) == `SFEC_CFILE_BASE && ap_addr[1:0] == 2'b00) begin
                    communications_register[ap_addr[3:2]] <= hwdata;
                end
            end
        end
    end

    // ****************************************************************
    // Visible state class and step.
    // ****************************************************************
    // Idle reads as 0/0, so a stall is easy to spot.
    always @* begin
        case (state)
            ST_C7S2: begin
                state_class = 3'd7;
                state_step  = 2'd2;
            end
            ST_C3S2: begin
                state_class = 3'd3;
                state_step  = 2'd2;
            end
            default: begin
                state_class = 3'd0;
                state_step  = 2'd0;
            end
        endcase
    end

endmodule // sfec_exec_control

// [core/sfec_regs.vh]
// Register map, fields and reset values of the execution control.
`ifndef SFEC_REGS_VH
`define SFEC_REGS_VH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define SFEC_CTRL_OFS    8'h00
`define SFEC_STAT_OFS    8'h04
`define SFEC_PC_OFS      8'h08
`define SFEC_TASK_BASE   8'h10
`define SFEC_CFILE_BASE  8'h20
`define SFEC_BANK_MASK   8'hF0

// ****************************************************************
// Control word fields.
// ****************************************************************
`define SFEC_CTRL_START  0
`define SFEC_CTRL_GRP_LO 1
`define SFEC_CTRL_GRP_HI 2
`define SFEC_CTRL_ROM    3
`define SFEC_CTRL_OP_LO  4
`define SFEC_CTRL_OP_HI  6
`define SFEC_CTRL_R_LO   8
`define SFEC_CTRL_R_HI   9
`define SFEC_CTRL_TN_LO  10
`define SFEC_CTRL_TN_HI  15
`define SFEC_CTRL_SZ_LO  16
`define SFEC_CTRL_SZ_HI  17
`define SFEC_CTRL_LN_LO  18
`define SFEC_CTRL_LN_HI  19

// ****************************************************************
// Status word fields.
// ****************************************************************
`define SFEC_STAT_BUSY   0
`define SFEC_STAT_CLS_LO 1
`define SFEC_STAT_STP_LO 4
`define SFEC_STAT_SKIP   6
`define SFEC_STAT_EA_LO  8

// ****************************************************************
// Group codes, shift kinds and reset values.
// ****************************************************************
`define SFEC_GRP_LOGIC   2'h0
`define SFEC_GRP_SHIFT   2'h1
`define SFEC_GRP_FSET    2'h2
`define SFEC_GRP_FTEST   2'h3
`define SFEC_SHK_CYCLIC  2'h2
`define SFEC_SHK_ARITH   2'h1
`define SFEC_RST_WORD    32'h0000_0000
`define SFEC_RST_PC      16'h0000

`endif

// [core/sfec_shift_step.v]
// One shifter cycle: shift by 1, 4, 8 or 16 and report the count left.
`timescale 1ns/1ps
`include "sfec_regs.vh"

module sfec_shift_step (
    input  wire [31:0] word,        // Word being shifted.
    input  wire [1:0]  kind,        // 0 logical, 1 arithmetic, 2 cyclic.
    input  wire        left,        // High for a left shift.
    input  wire [5:0]  count,       // Positions still to shift.
    output wire [31:0] result,      // Word after this cycle's shift.
    output wire [5:0]  new_count,   // Positions left after this cycle.
    output wire        more         // Shift update flag: another cycle is needed.
);

    reg [4:0] amount;

    // ****************************************************************
    // Shift one step.
    // ****************************************************************
    function [31:0] shift_by;
        input [31:0] w;
        input [1:0]  k;
        input        l;
        input [4:0]  a;
        begin
            if (k == `SFEC_SHK_CYCLIC) begin
                shift_by = l ? ((w << a) | (w >> (6'd32 - {1'b0, a})))
                             : ((w >> a) | (w << (6'd32 - {1'b0, a})));
            end else if (l) begin
                shift_by = w << a;
            end else if (k == `SFEC_SHK_ARITH) begin
                shift_by = $signed(w) >>> a;
            end else begin
                shift_by = w >> a;
            end
        end
    endfunction

    // Largest step that does not overshoot; only cyclic shifts may take 16.
    always @* begin
        if (kind == `SFEC_SHK_CYCLIC && count >= 6'd16) begin
            amount = 5'd16;
        end else if (count >= 6'd8) begin
            amount = 5'd8;
        end else if (count >= 6'd4) begin
            amount = 5'd4;
        end else if (count != 6'd0) begin
            amount = 5'd1;
        end else begin
            amount = 5'd0;
        end
    end

    assign result    = shift_by(word, kind, left, amount);
    assign new_count = count - {1'b0, amount};
    assign more      = (count > {1'b0, amount});

endmodule // sfec_shift_step

// [testbench/sfec_exec_control_chk.sv]
// Concurrent checks on the ports of the shift and flag execution control.
`timescale 1ns/1ps
module sfec_exec_control_chk (
    input wire logic        hclk, hresetn, hreadyout, hresp, buffer_avail,  // Clock, reset, bus.
    input wire logic [31:0] memory_buffer_data_word, next_instruction,      // Words.
    input wire logic [15:0] memory_buffer_addr, read_address,               // Addresses.
    input wire logic        pipe_advance, pipe_from_buffer, pipe_rom_method, // Pipe pulses.
    input wire logic        read_request, read_from_rom, skip_taken,        // Skip outputs.
    input wire logic [2:0]  state_class,                                    // State class.
    input wire logic [1:0]  state_step                                      // Step.
);
    // One clock domain.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bad bus answer");
    a_adv_one_src: assert property (pipe_advance |-> pipe_from_buffer != pipe_rom_method) else $error("bad source");
    a_src_with_adv: assert property ((pipe_from_buffer || pipe_rom_method) |-> pipe_advance) else $error("lone source");
    a_adv_pulse: assert property (pipe_advance |=> !pipe_advance) else $error("long advance");
    a_buf_first: assert property (pipe_from_buffer |-> $past(buffer_avail)) else $error("no buffer");
    a_next_word: assert property (pipe_from_buffer |-> next_instruction == $past(memory_buffer_data_word))
        else $error("bad next word");
    a_skip_class: assert property (read_request |-> state_class == 3'h3 && state_step == 2'h2 && skip_taken
        && !pipe_advance) else $error("bad skip state");
    a_skip_addr: assert property (read_request && !read_from_rom |-> read_address == $past(memory_buffer_addr))
        else $error("bad skip address");
    a_step_two: assert property (state_class != 3'h0 |-> state_step == 2'h2) else $error("bad step");
    // Scenarios seen.
    c_rom_adv: cover property (pipe_rom_method);
    c_rom_skip: cover property (read_request && read_from_rom);
    c_dep_wait: cover property (state_class == 3'h3);
endmodule // sfec_exec_control_chk
bind sfec_exec_control sfec_exec_control_chk u_chk (.*);

// [testbench/sfec_buffer_model.sv]
// Behavioural memory buffer synchroniser beside the execution control.
`timescale 1ns/1ps
module sfec_buffer_model (
    input  wire logic   hclk, hresetn, stall, dep_req,  // Clock, reset, empty buffer, dependency.
    output logic        buffer_avail, dependency,       // Buffer ready, dependency level.
    output logic [31:0] memory_buffer_data_word,        // Buffer word.
    output logic [15:0] memory_buffer_addr              // Its address.
);
    // A moving address exposes late captures.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) memory_buffer_addr <= 16'h0000;
        else memory_buffer_addr <= memory_buffer_addr + 16'h0001;
    end
    // Words never repeat; a stall empties the buffer.
    assign memory_buffer_data_word = {~memory_buffer_addr, memory_buffer_addr};
    assign buffer_avail = hresetn && !stall;
    assign dependency = dep_req;
endmodule // sfec_buffer_model

// [testbench/test_shift_and_flag_exec_control.sv]
// Self-checking bench for the shift and flag execution control.
`timescale 1ns/1ps
module test_shift_and_flag_exec_control;
    typedef struct packed {logic [15:0] ctrl; logic [31:0] exp;} sfec_row_t;
    localparam logic [31:0] A = 32'h8765_4321;
    localparam logic [31:0] B = 32'h0FF0_F00F;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, stall = 1'b0, dep_req = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, q;
    logic s3, s7, adv, src, got_rq;
    logic [15:0] got_ra, exp_ra;
    wire hreadyout, hresp, buffer_avail, dependency, pipe_advance, pipe_from_buffer, pipe_rom_method;
    wire read_request, read_from_rom, skip_taken;
    wire [31:0] hrdata, memory_buffer_data_word, next_instruction;
    wire [15:0] memory_buffer_addr, read_address;
    wire [2:0] state_class;
    wire [1:0] state_step;
    int fails = 0, checked = 0, cyc = 0, na;
    sfec_row_t rows [8] = '{'{16'h0401, A & B}, '{16'h0411, A | B}, '{16'h0421, A ^ B}, '{16'h0431, ~(A ^ B)},
        '{16'h0409, A & B}, '{16'h1003, A >> 4}, '{16'h5063, {A[11:0], A[31:12]}}, '{16'h0C1B, 32'hF0EC_A864}};
    sfec_exec_control DUT (.*, .hsize(3'h2), .hready(hreadyout), .active_processor_number(3'h3),
        .aligner_byte_reference(4'h1));
    sfec_buffer_model u_buf (.*);
    // Clock and run ceiling.
    always #25 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            give_verdict();
        end
    end
    // One word transfer; read data taken at the data phase edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {htrans, hwrite, haddr} <= {2'h2, w, 24'h00_0000, a};
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        {htrans, hwdata} <= {2'h0, d};
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        q = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Start an instruction; watch until the pipe advances.
    task automatic run(input logic [15:0] c, input int hold);
        bus(1'b1, 8'h00, {16'h0000, c});
        {s3, adv, got_rq} = 3'b000;
        for (int n = 0; n < 40 && !adv; n++) begin
            @(negedge hclk);
            if (n == hold) stall <= 1'b0;
            if (n == 0) s7 = state_class === 3'h7;
            if (state_class === 3'h3) s3 = 1'b1;
            if (read_request === 1'b1) {got_rq, got_ra, exp_ra} = {1'b1, read_address, memory_buffer_addr - 16'h0001};
            {adv, src, na} = {pipe_advance === 1'b1, pipe_rom_method === 1'b1, n};
        end
    endtask
    task automatic give_verdict();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Table rows, then hand cases.
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h04, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            stall <= rows[i].ctrl[3];
            bus(1'b1, 8'h10, A);
            bus(1'b1, 8'h14, B);
            run(rows[i].ctrl, 99);
            chk({31'h0, s7 & adv}, 32'h0000_0001);
            chk({31'h0, src}, {31'h0, rows[i].ctrl[3]});
            bus(1'b0, 8'h10, 32'h0000_0000);
            chk(q, rows[i].exp);
            $display("row %0d done", i);
        end
        stall <= 1'b1;
        run(16'h0401, 6);
        chk({31'h0, na > 6}, 32'h0000_0001);
        dep_req <= 1'b1;
        run(16'h1003, 99);
        chk({31'h0, s3}, 32'h0000_0001);
        bus(1'b1, 8'h20, 32'h1234_5600);
        run(16'h0015, 99);
        chk({31'h0, s3}, 32'h0000_0001);
        bus(1'b0, 8'h20, 32'h0000_0000);
        chk(q, 32'h1234_5608);
        dep_req <= 1'b0;
        run(16'h0017, 99);
        chk({15'h0, got_rq, got_ra}, {15'h0, 1'b1, exp_ra});
        bus(1'b0, 8'h08, 32'h0000_0000);
        chk(q, {16'h0000, got_ra + 16'h0001});
        run(16'h0007, 99);
        chk({31'h0, got_rq | ~adv}, 32'h0000_0000);
        stall <= 1'b1;
        bus(1'b1, 8'h08, 32'h0000_0040);
        run(16'h001F, 99);
        chk({15'h0, read_from_rom, got_ra}, {15'h0, 1'b1, 16'h0040});
        $display("hand cases done");
        give_verdict();
    end
endmodule // test_shift_and_flag_exec_control
